//--- logic/edge_count_led_current_control.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Setting register changes only from counted rising edges or shutdown.
// - Host holds line high 500 us after burst; the step variants apply the level only then.
// - Line low longer than 500 us shuts all current outputs off.
// - Entering shutdown clears the setting register to zero.
// - In the step variants the first rising edge from shutdown selects the maximum current step; the duty variant sets step 0.
// - In the step variants every further rising edge advances the register one step lower until the last step, where it holds.
// - Sixteen-step variant: steps 1..16 give 20.1 down to 0.67 mA.
// - Eight-step variant: steps 1..8 use every second sixteen-step level.
// - Duty variant: current follows duty cycle, least step is full scale / 30.
// - Duty 100% down to 10% maps roughly linearly to 20 down to 2.6 mA.
// - Duty variant shuts down after the line stays low 500 us.
// - At 25 kHz the duty profile gives about 10.4 mA at 50%.
module edge_count_led_current_control
#(
  parameter int unsigned OFF_CYCLES = led_ctl_pkg::OFF_CYCLES,
  parameter int unsigned LAT_CYCLES = led_ctl_pkg::LAT_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable and programming pin
  input wire logic ctl_line,
  // Variant strap
  input wire logic [1:0] variant_sel,
  // Current drive
  output logic [led_ctl_pkg::CHANNELS-1:0] led_current_outputs,
  output logic [led_ctl_pkg::LVL_W-1:0] current_level,
  output logic [led_ctl_pkg::LVL_W-1:0] step_data
);
  localparam logic [15:0] OFF_LIM = 16'(OFF_CYCLES);
  localparam logic [15:0] LAT_LIM = 16'(LAT_CYCLES);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic line_prev;
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic [15:0] high_len;
  logic armed;
  led_ctl_pkg::state_t state;
  led_ctl_pkg::state_t next_state;
  logic [4:0] next_data;
  logic [4:0] next_level;
  logic next_armed;
  logic [4:0] quotient;
  logic div_done;

  // Pin and strap pass two flops before anything looks at them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      line_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {variant_sel, ctl_line};
      sync2 <= sync1;
      line_prev <= sync2[0];
    end
  end

  // Edge and variant decode
  wire line = sync2[0];
  wire [1:0] variant = sync2[2:1];
  wire rise = line & ~line_prev;
  wire fall = ~line & line_prev;
  wire duty = (variant == led_ctl_pkg::VAR_DUTY);
  wire [4:0] step_max = (variant == led_ctl_pkg::VAR_8STEP) ? led_ctl_pkg::STEPS_8 :
                        led_ctl_pkg::STEPS_16;

  // Timeout strobes fire once, in the cycle the limit is reached
  wire off_hit = ~line & (low_cnt == OFF_LIM - 16'h0001);
  wire lat_hit = line & (hi_cnt == LAT_LIM - 16'h0001);

  // Low and high timers; the high timer restarts at every rising edge
  always_ff @(posedge clk)
  begin
    if (rst || line)
      low_cnt <= 16'h0000;
    else if (low_cnt != OFF_LIM)
      low_cnt <= low_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !line)
      hi_cnt <= 16'h0000;
    else if (hi_cnt != LAT_LIM)
      hi_cnt <= hi_cnt + 16'h0001;
  end

  // Period and high-time capture for the duty variant
  always_ff @(posedge clk)
  begin
    if (rst || rise)
      per_cnt <= 16'h0001;
    else if (per_cnt != 16'hFFFF)
      per_cnt <= per_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      high_len <= 16'h0000;
    else if (fall)
      high_len <= hi_cnt;
  end

  // Step advance saturates at the variant's last step
  wire [4:0] data_adv = (step_data == step_max) ? step_data : step_data + 5'h01;

  // Serial level tables in units of full scale / 30
  wire [5:0] lvl16_raw = led_ctl_pkg::LVL16_BASE - {step_data, 1'b0};
  wire [5:0] lvl8_raw = led_ctl_pkg::LVL8_BASE - {step_data[3:0], 2'b00};
  wire [4:0] lvl16 = (step_data == led_ctl_pkg::STEPS_16) ? led_ctl_pkg::LVL_LSB :
                     lvl16_raw[4:0];
  wire [4:0] serial_level = (variant == led_ctl_pkg::VAR_8STEP) ? lvl8_raw[4:0] : lvl16;

  // Duty level is 29 * duty + 1, never above full scale
  wire [4:0] q_plus = quotient + 5'h01;
  wire [4:0] duty_level = (quotient >= led_ctl_pkg::DUTY_SLOPE) ? led_ctl_pkg::LVL_FULL :
                          q_plus;
  wire div_start = duty & rise & armed & (state != led_ctl_pkg::ST_OFF);
  wire [19:0] duty_num = {4'h0, high_len} * {15'h0000, led_ctl_pkg::DUTY_SLOPE};

  // Fractional duty by division; a period takes at least 800 cycles, the divider six
  led_duty_divider u_div
  (
    .clk(clk),
    .rst(rst),
    .start(div_start),
    .num(duty_num),
    .den(per_cnt),
    .quotient(quotient),
    .done(div_done)
  );

  // Line state machine shared by both interface styles
  always_comb
  begin
    next_state = state;
    next_data = step_data;
    next_level = current_level;
    next_armed = armed;
    unique case (state)
      led_ctl_pkg::ST_OFF:
      begin
        if (rise)
        begin
          next_state = led_ctl_pkg::ST_COUNT;
          next_data = duty ? 5'h00 : 5'h01;
          next_armed = 1'b1;
        end
      end
      led_ctl_pkg::ST_COUNT, led_ctl_pkg::ST_ON:
      begin
        if (off_hit)
        begin
          next_state = led_ctl_pkg::ST_OFF;
          next_data = 5'h00;
          next_level = 5'h00;
          next_armed = 1'b0;
        end
        else if (duty)
        begin
          if (lat_hit)
          begin
            next_state = led_ctl_pkg::ST_ON;
            next_level = led_ctl_pkg::LVL_FULL;
            next_armed = 1'b0;
          end
          else if (div_done)
          begin
            next_state = led_ctl_pkg::ST_ON;
            next_level = duty_level;
          end
          else if (rise)
            next_armed = 1'b1;
        end
        else if (rise)
        begin
          next_state = led_ctl_pkg::ST_COUNT;
          next_data = data_adv;
        end
        else if (lat_hit && state == led_ctl_pkg::ST_COUNT)
        begin
          next_state = led_ctl_pkg::ST_ON;
          next_level = serial_level;
        end
      end
      default:
      begin
        next_state = led_ctl_pkg::ST_OFF;
        next_data = 5'h00;
        next_level = 5'h00;
        next_armed = 1'b0;
      end
    endcase
  end

  // Reset lands in shutdown with the register cleared
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= led_ctl_pkg::ST_OFF;
      step_data <= 5'h00;
      current_level <= 5'h00;
      armed <= 1'b0;
      led_current_outputs <= 3'h0;
    end
    else
    begin
      state <= next_state;
      step_data <= next_data;
      current_level <= next_level;
      armed <= next_armed;
      led_current_outputs <= {led_ctl_pkg::CHANNELS{next_level != 5'h00}};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence serial_rise_s;
    rise && !duty;
  endsequence

  sequence div_run_s;
    div_start ##[1:8] div_done;
  endsequence

  off_outputs_a: assert property (off_hit |=> led_current_outputs == 3'h0)
    else $error("Outputs still on after off timeout");
  off_clear_a: assert property (off_hit
                                |=> step_data == 5'h00 && state == led_ctl_pkg::ST_OFF)
    else $error("Register not cleared at shutdown");
  wake_max_a: assert property (serial_rise_s and state == led_ctl_pkg::ST_OFF
                               |=> step_data == 5'h01)
    else $error("First edge did not select top step");
  step_adv_a: assert property (serial_rise_s and state != led_ctl_pkg::ST_OFF
                               and step_data < step_max
                               |=> step_data == $past(step_data) + 5'h01)
    else $error("Edge did not advance step");
  step_hold_a: assert property (serial_rise_s and step_data == step_max
                                |=> $stable(step_data))
    else $error("Step moved past last step");
  edge_only_a: assert property ($changed(step_data) |-> $past(rise) || $past(off_hit))
    else $error("Register changed without edge or shutdown");
  apply_pause_a: assert property (!duty && $changed(current_level)
                                  && current_level != 5'h00 |-> $past(lat_hit))
    else $error("Level applied before latch pause");
  lvl16_ends_a: assert property (lat_hit && state == led_ctl_pkg::ST_COUNT
                                 && variant == led_ctl_pkg::VAR_16STEP
                                 && (step_data == 5'h01 || step_data == 5'h10)
                                 |=> current_level == (($past(step_data) == 5'h01)
                                                       ? 5'h1E : 5'h01))
    else $error("Sixteen-step table end wrong");
  lvl8_last_a: assert property (lat_hit && state == led_ctl_pkg::ST_COUNT
                                && variant == led_ctl_pkg::VAR_8STEP
                                && step_data == 5'h08 |=> current_level == 5'h02)
    else $error("Eight-step last level wrong");
  duty_full_a: assert property (duty && lat_hit && state != led_ctl_pkg::ST_OFF
                                |=> current_level == 5'h1E)
    else $error("Constant high not full scale");
  duty_div_a: assert property (div_start |-> div_run_s)
    else $error("Duty measurement did not finish");
  duty_off_a: assert property (duty && off_hit |=> current_level == 5'h00 [*2])
    else $error("Duty variant did not shut down");
endmodule
`default_nettype wire

//--- logic/led_ctl_pkg.sv
`default_nettype none
package led_ctl_pkg;
  // Core clock and timing figures
  localparam longint CLK_HZ = 40_000_000;
  localparam longint US_PER_S = 1_000_000;
  localparam longint T_OFF_US = 500;
  localparam longint LATCH_PAUSE_TIME_US = 500;
  // Least times round up to whole cycles
  localparam int OFF_CYCLES = int'((T_OFF_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int LAT_CYCLES = int'((LATCH_PAUSE_TIME_US * CLK_HZ + US_PER_S - 1) / US_PER_S);

  // Timer and measurement widths
  localparam int TMR_W = 16;
  localparam int NUM_W = 20;
  localparam int LVL_W = 5;
  localparam int CHANNELS = 3;

  // Variant strap codes
  localparam logic [1:0] VAR_16STEP = 2'h0;
  localparam logic [1:0] VAR_8STEP = 2'h1;
  localparam logic [1:0] VAR_DUTY = 2'h2;

  // Step counts and level scale, level unit is full scale / 30
  localparam logic [4:0] STEPS_16 = 5'h10;
  localparam logic [4:0] STEPS_8 = 5'h08;
  localparam logic [4:0] LVL_FULL = 5'h1E;
  localparam logic [4:0] LVL_LSB = 5'h01;
  localparam logic [5:0] LVL16_BASE = 6'h20;
  localparam logic [5:0] LVL8_BASE = 6'h22;
  localparam logic [4:0] DUTY_SLOPE = 5'h1D;
  localparam logic [2:0] DIV_TOP_BIT = 3'h4;

  // Control line states
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_COUNT = 3'b010,
    ST_ON = 3'b100
  } state_t;
endpackage
`default_nettype wire

//--- logic/led_duty_divider.sv
`timescale 1ns/1ps
`default_nettype none
module led_duty_divider
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [led_ctl_pkg::NUM_W-1:0] num,
  input wire logic [led_ctl_pkg::TMR_W-1:0] den,
  // Answer
  output logic [led_ctl_pkg::LVL_W-1:0] quotient,
  output logic done
);
  logic busy;
  logic [2:0] idx;
  logic [led_ctl_pkg::NUM_W-1:0] rem;
  logic [led_ctl_pkg::NUM_W-1:0] den_q;
  logic [led_ctl_pkg::NUM_W-1:0] trial;
  logic fits;

  // Divisor is held from the start; the period counter restarts on that same edge
  assign trial = den_q << idx;
  assign fits = (rem >= trial);

  // Restoring division, one quotient bit a cycle; quotient never exceeds 29
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      idx <= 3'h0;
      rem <= '0;
      den_q <= '0;
      quotient <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy <= 1'b1;
        idx <= led_ctl_pkg::DIV_TOP_BIT;
        rem <= num;
        den_q <= {4'h0, den};
        quotient <= '0;
      end
      else if (busy)
      begin
        if (fits)
        begin
          rem <= rem - trial;
          quotient[idx] <= 1'b1;
        end
        if (idx == 3'h0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          idx <= idx - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/host_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_line_model
(
  // Clock
  input wire logic clk,
  // Programming line
  output var logic ctl_line
);
  initial ctl_line = 1'b0;

  // Level changed just after an edge, then held; whole-cycle spacing only
  task automatic hold(input logic lvl, input int cycles);
    ctl_line <= lvl;
    repeat (cycles) @(posedge clk);
  endtask

  // Burst of rising edges; lows stay short so none reads as a shutdown
  task automatic burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        hold(1'b0, 12);
      hold(1'b1, 12);
    end
  endtask

  // Fixed duty pattern; callers keep the period at 800 cycles or more
  task automatic pwm(input int hi, input int period, input int count);
    repeat (count)
    begin
      hold(1'b1, hi);
      hold(1'b0, period - hi);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/edge_count_led_current_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module edge_count_led_current_control_test;
  // Pause figures shortened so the run stays brief
  localparam int unsigned PAUSE = 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] variant_sel = 2'h0;
  logic ctl_line;
  logic [2:0] leds;
  logic [4:0] level;
  logic [4:0] step;
  int fails = 0;
  int n_compared = 0;
  // Burst lengths per variant, some past the last step
  int serial16[6] = '{1, 2, 8, 15, 16, 20};
  int serial8[4] = '{1, 3, 8, 9};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  host_line_model i_host (.clk(clk), .ctl_line(ctl_line));

  edge_count_led_current_control #(.OFF_CYCLES(PAUSE), .LAT_CYCLES(PAUSE)) i_dut (
    .clk(clk),
    .rst(rst),
    .ctl_line(ctl_line),
    .variant_sel(variant_sel),
    .led_current_outputs(leds),
    .current_level(level),
    .step_data(step)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Variant is a strap, so it only changes under reset
  task automatic do_reset(input logic [1:0] v);
    rst <= 1'b1;
    variant_sel <= v;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset leds", {5'h0, leds}, 8'h00);
    check("reset step", {3'h0, step}, 8'h00);
  endtask

  // Burst from shutdown, latch, then shut down again
  task automatic t_serial(input logic [1:0] v, input int n);
    int cap;
    int lvl;
    cap = (v == 2'h1) ? ((n > 8) ? 8 : n) : ((n > 16) ? 16 : n);
    lvl = (v == 2'h1) ? 34 - 4 * cap : ((cap == 16) ? 1 : 32 - 2 * cap);
    i_host.burst(n);
    i_host.hold(1'b1, 20);
    check("step", {3'h0, step}, 8'(cap));
    check("early level", {3'h0, level}, 8'h00);
    i_host.hold(1'b1, PAUSE + 10);
    check("level", {3'h0, level}, 8'(lvl));
    check("leds on", {5'h0, leds}, 8'h07);
    i_host.hold(1'b0, PAUSE + 10);
    check("off leds", {5'h0, leds}, 8'h00);
    check("off level", {3'h0, level}, 8'h00);
    check("off step", {3'h0, step}, 8'h00);
  endtask

  // Edges after a latched setting keep counting from it
  task automatic t_resume();
    i_host.burst(3);
    i_host.hold(1'b1, PAUSE + 10);
    check("first level", {3'h0, level}, 8'h1A);
    i_host.hold(1'b0, 12);
    i_host.burst(2);
    i_host.hold(1'b1, 20);
    check("held level", {3'h0, level}, 8'h1A);
    check("resumed step", {3'h0, step}, 8'h05);
    i_host.hold(1'b1, PAUSE + 10);
    check("resumed level", {3'h0, level}, 8'h16);
    i_host.hold(1'b0, PAUSE + 10);
  endtask

  // Duty variant: level is floor(29 * high / period) + 1
  task automatic t_duty(input int hi, input logic [7:0] exp);
    i_host.pwm(hi, 800, 4);
    check("duty level", {3'h0, level}, exp);
    check("duty leds", {5'h0, leds}, 8'h07);
    check("duty step", {3'h0, step}, 8'h00);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (serial16[i])
      t_serial(2'h0, serial16[i]);
    t_resume();
    // Spare strap code falls back to the sixteen-step table
    do_reset(2'h3);
    t_serial(2'h3, 4);
    do_reset(2'h1);
    foreach (serial8[i])
      t_serial(2'h1, serial8[i]);
    do_reset(2'h2);
    t_duty(400, 8'h0F);
    t_duty(240, 8'h09);
    t_duty(80, 8'h03);
    i_host.hold(1'b1, PAUSE + 10);
    check("full level", {3'h0, level}, 8'h1E);
    i_host.hold(1'b0, PAUSE + 10);
    check("duty off", {5'h0, leds}, 8'h00);
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 39000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
